// ===== pkg/srh_pkg.sv
package srh_pkg;

    // status group geometry
    localparam int SRH_GRP_W      = 16;
    localparam int SRH_MSB_BIT    = 15;
    localparam int SRH_NUM_GRP    = 3;

    // group indices
    localparam int SRH_GRP_DEV    = 0;
    localparam int SRH_GRP_QUES   = 1;
    localparam int SRH_GRP_OPER   = 2;

    // status byte bit positions
    localparam int SRH_STB_DEV    = 1;
    localparam int SRH_STB_ERRQ   = 2;
    localparam int SRH_STB_QUES   = 3;
    localparam int SRH_STB_MAV    = 4;
    localparam int SRH_STB_ESB    = 5;
    localparam int SRH_STB_MSS    = 6;
    localparam int SRH_STB_OPER   = 7;

    // sub-register selectors
    typedef enum logic [2:0] {
        SRH_SUB_COND,
        SRH_SUB_PTR,
        SRH_SUB_NTR,
        SRH_SUB_EVT,
        SRH_SUB_ENA
    } srh_sub_t;

    // top-level selectors
    typedef enum logic [1:0] {
        SRH_TOP_STB,
        SRH_TOP_SRE,
        SRH_TOP_PPE
    } srh_top_t;

    // reset values and valid-bit mask
    localparam logic [15:0] SRH_PTR_RST   = 16'h7fff;
    localparam logic [15:0] SRH_NTR_RST   = 16'h0000;
    localparam logic [15:0] SRH_ENA_RST   = 16'h0000;
    localparam logic [7:0]  SRH_SRE_RST   = 8'h00;
    localparam logic [7:0]  SRH_PPE_RST   = 8'h00;
    localparam logic [15:0] SRH_VALID_MSK = 16'h7fff;

    // register access request from the command interpreter
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        top;
        logic [1:0]  grp;
        logic [2:0]  sub;
        logic [15:0] wdata;
    } srh_req_t;

endpackage

// ===== core/srh_group.sv
`timescale 1ns/1ps
`default_nettype none
module srh_group
    import srh_pkg::*;
#(
    parameter int W = srh_pkg::SRH_GRP_W
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    // condition inputs
    input  wire logic [W-1:0] cond_i,
    // register access
    input  wire logic         sel_i,
    input  wire logic         rd_i,
    input  wire logic         wr_i,
    input  wire logic [2:0]   sub_i,
    input  wire logic [W-1:0] wdata_i,
    // results
    output logic [W-1:0]      rdata_o,
    output logic              summary_o
);
    logic [W-1:0] cond_r, cond_nxt;
    logic [W-1:0] ptr_r, ptr_nxt;
    logic [W-1:0] ntr_r, ntr_nxt;
    logic [W-1:0] evt_r, evt_nxt;
    logic [W-1:0] ena_r, ena_nxt;
    logic         sum_r, sum_nxt;
    logic [W-1:0] rise, fall, hit;

    always_comb begin
        cond_nxt = cond_i & SRH_VALID_MSK[W-1:0];
        rise     = cond_nxt & ~cond_r;
        fall     = ~cond_nxt & cond_r;
        hit      = (rise & ptr_r) | (fall & ntr_r);
        ptr_nxt  = ptr_r;
        ntr_nxt  = ntr_r;
        ena_nxt  = ena_r;
        evt_nxt  = evt_r;
        if (sel_i && rd_i && srh_sub_t'(sub_i) == SRH_SUB_EVT) begin
            evt_nxt = '0;
        end
        evt_nxt = (evt_nxt | hit) & SRH_VALID_MSK[W-1:0];
        // condition and event take no writes
        if (sel_i && wr_i) begin
            case (srh_sub_t'(sub_i))
                SRH_SUB_PTR: ptr_nxt = wdata_i & SRH_VALID_MSK[W-1:0];
                SRH_SUB_NTR: ntr_nxt = wdata_i & SRH_VALID_MSK[W-1:0];
                SRH_SUB_ENA: ena_nxt = wdata_i & SRH_VALID_MSK[W-1:0];
                default:     ;
            endcase
        end
        sum_nxt = |(evt_nxt & ena_nxt);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cond_r <= '0;
            ptr_r  <= SRH_PTR_RST[W-1:0];
            ntr_r  <= SRH_NTR_RST[W-1:0];
            evt_r  <= '0;
            ena_r  <= SRH_ENA_RST[W-1:0];
            sum_r  <= 1'b0;
        end else begin
            cond_r <= cond_nxt;
            ptr_r  <= ptr_nxt;
            ntr_r  <= ntr_nxt;
            evt_r  <= evt_nxt;
            ena_r  <= ena_nxt;
            sum_r  <= sum_nxt;
        end
    end

    always_comb begin
        case (srh_sub_t'(sub_i))
            SRH_SUB_COND: rdata_o = cond_r;
            SRH_SUB_PTR:  rdata_o = ptr_r;
            SRH_SUB_NTR:  rdata_o = ntr_r;
            SRH_SUB_EVT:  rdata_o = evt_r;
            SRH_SUB_ENA:  rdata_o = ena_r;
            default:      rdata_o = '0;
        endcase
    end

    assign summary_o = sum_r;
endmodule
`default_nettype wire

// ===== core/srh_srq.sv
`timescale 1ns/1ps
`default_nettype none
module srh_srq
    import srh_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    // status byte without master summary
    input  wire logic [7:0] stb_i,
    input  wire logic [7:0] sre_i,
    input  wire logic       err_new_i,
    // request
    output logic            srq_o
);
    logic [7:0] prev_r, prev_nxt;
    logic [7:0] sre_eff;
    logic       srq_r, srq_nxt;

    always_comb begin
        sre_eff = sre_i;
        sre_eff[SRH_STB_MSS] = 1'b0;
        prev_nxt = stb_i;
        srq_nxt = (|(stb_i & ~prev_r & sre_eff))
                | (err_new_i & sre_eff[SRH_STB_ERRQ]);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_r <= 8'h00;
            srq_r  <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            srq_r  <= srq_nxt;
        end
    end

    assign srq_o = srq_r;
endmodule
`default_nettype wire

// ===== core/srh_top.sv
// Function
// - five 16-bit sub-registers per group, bits handled independently
// - bit 15 held at zero in every sub-register
// - condition follows the hardware inputs only, sampled on every clock
// - condition is read-only; writes ignored, reads non-destructive
// - rising condition sets event when positive filter bit set
// - falling condition sets event when negative filter bit set
// - both transition filters read/write, reads non-destructive
// - event latches filtered transitions until read
// - event read-only, every read clears it except bits set by a transition in the same cycle
// - summary is OR of event AND enable
// - enable read/write anytime, reads non-destructive
// - summary feeds a status byte bit, not a condition bit of another group
// - status byte bit 6 set when any enabled bit set
// - enable bit 6 ignored for service request
// - service request on enabled status byte bit rising
// - bits 1, 3, 7 carry device, questionable, operation summaries
// - bit 2 means error queue non-empty; each new entry requests
// - bit 4 set while output queue holds a response
// - bit 5 set when enabled standard event bit set
// - individual status flag is OR of status byte AND parallel mask
`timescale 1ns/1ps
`default_nettype none
module srh_top
    import srh_pkg::*;
#(
    parameter int W = srh_pkg::SRH_GRP_W
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       resetn_i,
    // hardware conditions per group
    input  wire logic [W-1:0]               dev_cond_i,
    input  wire logic [W-1:0]               ques_cond_i,
    input  wire logic [W-1:0]               oper_cond_i,
    // queue and standard event state
    input  wire logic                       err_nonempty_i,
    input  wire logic                       err_new_i,
    input  wire logic                       out_avail_i,
    input  wire logic [7:0]                 std_evt_i,
    input  wire logic [7:0]                 std_ena_i,
    // register access
    input  wire srh_pkg::srh_req_t          req_i,
    output logic [W-1:0]                    rdata_o,
    // bus side
    output logic [7:0]                      status_byte_o,
    output logic                            srq_o,
    output logic                            ist_o
);
    import srh_pkg::*;

    logic [W-1:0] grp_rdata [SRH_NUM_GRP];
    logic [SRH_NUM_GRP-1:0] grp_sum;
    logic [W-1:0] cond_in [SRH_NUM_GRP];
    logic [7:0] sre_r, sre_nxt;
    logic [7:0] ppe_r, ppe_nxt;
    logic [7:0] stb_r, stb_nxt;
    logic [7:0] stb_base;
    logic [W-1:0] rdata_r, rdata_nxt;
    logic ist_r, ist_nxt;
    logic srq_w;

    always_comb begin
        cond_in[SRH_GRP_DEV]  = dev_cond_i;
        cond_in[SRH_GRP_QUES] = ques_cond_i;
        cond_in[SRH_GRP_OPER] = oper_cond_i;
    end

    genvar g;
    generate
        for (g = 0; g < SRH_NUM_GRP; g++) begin : gen_grp
            srh_group #(.W(W)) u_grp (
                .mclk_i   (mclk_i),
                .resetn_i (resetn_i),
                .cond_i   (cond_in[g]),
                .sel_i    (!req_i.top && req_i.grp == 2'(g)),
                .rd_i     (req_i.rd),
                .wr_i     (req_i.wr),
                .sub_i    (req_i.sub),
                .wdata_i  (req_i.wdata[W-1:0]),
                .rdata_o  (grp_rdata[g]),
                .summary_o(grp_sum[g])
            );
        end
    endgenerate

    always_comb begin
        stb_base = 8'h00;
        stb_base[SRH_STB_DEV]  = grp_sum[SRH_GRP_DEV];
        stb_base[SRH_STB_ERRQ] = err_nonempty_i;
        stb_base[SRH_STB_QUES] = grp_sum[SRH_GRP_QUES];
        stb_base[SRH_STB_MAV]  = out_avail_i;
        stb_base[SRH_STB_ESB]  = |(std_evt_i & std_ena_i);
        stb_base[SRH_STB_OPER] = grp_sum[SRH_GRP_OPER];
        stb_nxt = stb_base;
        stb_nxt[SRH_STB_MSS] = |(stb_base & sre_r & ~(8'h01 << SRH_STB_MSS));
        ist_nxt = |(stb_nxt & ppe_r);
        sre_nxt = sre_r;
        ppe_nxt = ppe_r;
        if (req_i.top && req_i.wr) begin
            case (srh_top_t'(req_i.grp))
                SRH_TOP_SRE: sre_nxt = req_i.wdata[7:0];
                SRH_TOP_PPE: ppe_nxt = req_i.wdata[7:0];
                default:     ;
            endcase
        end
        if (req_i.top) begin
            case (srh_top_t'(req_i.grp))
                SRH_TOP_STB: rdata_nxt = {8'h00, stb_r};
                SRH_TOP_SRE: rdata_nxt = {8'h00, sre_r};
                SRH_TOP_PPE: rdata_nxt = {8'h00, ppe_r};
                default:     rdata_nxt = '0;
            endcase
        end else if (req_i.grp < 2'(SRH_NUM_GRP)) begin
            rdata_nxt = grp_rdata[req_i.grp];
        end else begin
            rdata_nxt = '0;
        end
    end

    srh_srq u_srq (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .stb_i    (stb_base),
        .sre_i    (sre_r),
        .err_new_i(err_new_i),
        .srq_o    (srq_w)
    );

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sre_r   <= SRH_SRE_RST;
            ppe_r   <= SRH_PPE_RST;
            stb_r   <= 8'h00;
            ist_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            sre_r   <= sre_nxt;
            ppe_r   <= ppe_nxt;
            stb_r   <= stb_nxt;
            ist_r   <= ist_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o       = rdata_r;
    assign status_byte_o = stb_r;
    assign ist_o         = ist_r;
    assign srq_o         = srq_w;
endmodule
`default_nettype wire

// ===== verif/srh_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module srh_ctrl_model (
    // bus side
    input  wire logic  mclk_i,
    input  wire logic  srq_i,
    // service requests seen by the controller
    output logic [7:0] srq_cnt_o
);
    // counter starts at zero so the output has one driver only
    logic [7:0] cnt_r = 8'h00;
    always @(posedge mclk_i) if (srq_i) cnt_r <= cnt_r + 8'h01;
    assign srq_cnt_o = cnt_r;
endmodule
`default_nettype wire

// ===== verif/srh_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module srh_top_props
    import srh_pkg::*;
#(
    parameter int W = 16
) (
    // clock, reset and inputs
    input wire logic             mclk_i,
    input wire logic             resetn_i,
    input wire logic             err_nonempty_i,
    input wire logic             out_avail_i,
    input wire logic [7:0]       std_evt_i,
    input wire logic [7:0]       std_ena_i,
    input wire srh_pkg::srh_req_t req_i,
    // outputs
    input wire logic [W-1:0]     rdata_o,
    input wire logic [7:0]       status_byte_o,
    input wire logic             srq_o
);
    logic [7:0] srmask_r;
    logic [7:0] srmask_nxt;
    logic       mss_w;
    logic       esb_w;
    assign mss_w = |(status_byte_o & srmask_r & 8'hbf);
    assign esb_w = |(std_evt_i & std_ena_i);
    // shadow of the request mask
    always_comb begin
        srmask_nxt = srmask_r;
        if (req_i.wr && req_i.top && req_i.grp == 2'd1) srmask_nxt = req_i.wdata[7:0];
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) srmask_r <= 8'h00;
        else srmask_r <= srmask_nxt;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    rd_msb_a: assert property (rdata_o[W-1] == 1'b0)
        else $error("read msb set");
    byte_unused_a: assert property (status_byte_o[0] == 1'b0)
        else $error("status bit 0 set");
    err_bit_a: assert property (err_nonempty_i [*4] |-> status_byte_o[2])
        else $error("error queue bit missing");
    mav_bit_a: assert property ($stable(out_avail_i) [*4] |-> status_byte_o[4] == out_avail_i)
        else $error("message bit wrong");
    esb_bit_a: assert property ($stable(esb_w) [*4] |-> status_byte_o[5] == esb_w)
        else $error("event summary bit wrong");
    mss_set_a: assert property (mss_w [*2] |-> ##[0:1] status_byte_o[6])
        else $error("master summary missing");
    mss_clr_a: assert property (!mss_w [*3] |-> !status_byte_o[6])
        else $error("master summary without cause");
    srq_cause_a: assert property (srq_o |-> mss_w)
        else $error("request without enabled bit");
    srq_rise_a: assert property ($rose(status_byte_o[4]) && srmask_r[4] |-> srq_o)
        else $error("request missing on rise");
    srq_c: cover property (srq_o);
    mss_c: cover property (status_byte_o[6]);
    err_c: cover property (err_nonempty_i && srq_o);
endmodule
bind srh_top srh_top_props #(.W(W)) srh_top_props_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .err_nonempty_i(err_nonempty_i),
    .out_avail_i(out_avail_i), .std_evt_i(std_evt_i), .std_ena_i(std_ena_i),
    .req_i(req_i), .rdata_o(rdata_o), .status_byte_o(status_byte_o), .srq_o(srq_o)
);
`default_nettype wire

// ===== verif/srh_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srh_top_tb;
    import srh_pkg::*;
    localparam int POS [3] = '{SRH_STB_DEV, SRH_STB_QUES, SRH_STB_OPER};
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [15:0] cond [3] = '{default: 16'h0000};
    logic        err_ne = 1'b0;
    logic        err_new = 1'b0;
    logic        out_av = 1'b0;
    logic [7:0]  sevt = 8'h00;
    logic [7:0]  sena = 8'h00;
    srh_req_t    req = '0;
    logic [15:0] rdata;
    logic [7:0]  sbyte;
    logic        srq;
    logic        ist;
    logic [7:0]  cnt;
    logic [7:0]  k;
    logic [15:0] c;
    logic [15:0] n;
    logic        rd_seen = 1'b0;
    logic [15:0] exp_q [$];
    int          err_total = 0;
    int          checked = 0;
    srh_top srh_top_i (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .dev_cond_i(cond[0]),
        .ques_cond_i(cond[1]), .oper_cond_i(cond[2]), .err_nonempty_i(err_ne),
        .err_new_i(err_new), .out_avail_i(out_av), .std_evt_i(sevt), .std_ena_i(sena),
        .req_i(req), .rdata_o(rdata), .status_byte_o(sbyte), .srq_o(srq), .ist_o(ist)
    );
    srh_ctrl_model srh_ctrl_model_i (.mclk_i(mclk_i), .srq_i(srq), .srq_cnt_o(cnt));
    initial forever #50 mclk_i = ~mclk_i;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int cyc);
        repeat (cyc) @(posedge mclk_i);
    endtask
    task automatic op(input logic w, input logic t, input logic [1:0] g,
                      input logic [2:0] s, input logic [15:0] d);
        @(posedge mclk_i);
        req <= '{rd: !w, wr: w, top: t, grp: g, sub: s, wdata: d};
        @(posedge mclk_i);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic t, input logic [1:0] g, input logic [2:0] s,
                      input logic [15:0] exp);
        exp_q.push_back(exp);
        op(1'b0, t, g, s, 16'h0000);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read results land one edge after the request
    always @(posedge mclk_i) rd_seen <= req.rd;
    always @(negedge mclk_i) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
    end
    initial begin
        tick(3000);
        err_total++;
        finish_test();
    end
    initial begin
        c = 16'($urandom(32'h08ec));
        tick(2);
        resetn_i <= 1'b1;
        rd(1'b1, 2'd1, 3'd0, 16'h0000);
        rd(1'b1, 2'd3, 3'd0, 16'h0000);
        for (int g = 0; g < 3; g++) begin
            n = 16'($urandom());
            c = (16'($urandom()) & 16'hfffd) | 16'h0001;
            rd(1'b0, 2'(g), 3'd1, 16'h7fff);
            op(1'b1, 1'b0, 2'(g), 3'd2, n);
            rd(1'b0, 2'(g), 3'd2, n & 16'h7fff);
            rd(1'b0, 2'(g), 3'd4, 16'h0000);
            tick(1);
            cond[g] <= c;
            op(1'b1, 1'b0, 2'(g), 3'd0, ~c);
            rd(1'b0, 2'(g), 3'd0, c & 16'h7fff);
            rd(1'b0, 2'(g), 3'd0, c & 16'h7fff);
            rd(1'b0, 2'(g), 3'd3, c & 16'h7fff);
            rd(1'b0, 2'(g), 3'd3, 16'h0000);
            tick(1);
            cond[g] <= 16'h0000;
            tick(2);
            rd(1'b0, 2'(g), 3'd3, c & n & 16'h7fff);
            op(1'b1, 1'b0, 2'(g), 3'd4, 16'hffff);
            rd(1'b0, 2'(g), 3'd4, 16'h7fff);
            tick(1);
            cond[g] <= c;
            tick(3);
            rd(1'b1, 2'd0, 3'd0, 16'h0001 << POS[g]);
            rd(1'b0, 2'(g), 3'd3, c & 16'h7fff);
            tick(3);
            rd(1'b1, 2'd0, 3'd0, 16'h0000);
        end
        op(1'b1, 1'b1, 2'd1, 3'd0, 16'h00ff);
        k = cnt;
        tick(1);
        out_av <= 1'b1;
        tick(4);
        rd(1'b1, 2'd0, 3'd0, 16'h0050);
        check({8'h00, cnt}, {8'h00, k + 8'h01});
        out_av <= 1'b0;
        op(1'b1, 1'b1, 2'd1, 3'd0, 16'h0040);
        out_av <= 1'b1;
        tick(4);
        rd(1'b1, 2'd0, 3'd0, 16'h0010);
        check({8'h00, cnt}, {8'h00, k + 8'h01});
        sevt <= 8'h05;
        sena <= 8'h04;
        tick(3);
        rd(1'b1, 2'd0, 3'd0, 16'h0030);
        sena <= 8'h02;
        tick(3);
        rd(1'b1, 2'd0, 3'd0, 16'h0010);
        op(1'b1, 1'b1, 2'd1, 3'd0, 16'h0004);
        err_ne <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            tick(3);
            err_new <= 1'b1;
            tick(1);
            err_new <= 1'b0;
        end
        tick(4);
        rd(1'b1, 2'd0, 3'd0, 16'h0054);
        check({8'h00, sbyte}, 16'h0054);
        check({8'h00, cnt}, {8'h00, k + 8'h04});
        op(1'b1, 1'b1, 2'd2, 3'd0, 16'h0040);
        tick(2);
        check({15'h0000, ist}, 16'h0001);
        op(1'b1, 1'b1, 2'd2, 3'd0, 16'h0001);
        tick(2);
        check({15'h0000, ist}, 16'h0000);
        fork
            rd(1'b0, 2'd0, 3'd3, 16'h0000);
            begin
                tick(1);
                cond[0] <= cond[0] | 16'h0002;
            end
        join
        rd(1'b0, 2'd0, 3'd3, 16'h0002);
        // status byte takes no writes; masks and filters read back
        op(1'b1, 1'b1, 2'd0, 3'd0, 16'h00ff);
        rd(1'b1, 2'd0, 3'd0, 16'h0054);
        rd(1'b1, 2'd2, 3'd0, 16'h0001);
        op(1'b1, 1'b0, 2'd1, 3'd1, 16'h8005);
        rd(1'b0, 2'd1, 3'd1, 16'h0005);
        op(1'b1, 1'b0, 2'd1, 3'd3, 16'hffff);
        rd(1'b0, 2'd1, 3'd3, 16'h0000);
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) tick(1);
        if (exp_q.size() > 0) err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
